/* logic/pmrs_top.sv */
// power mode and reset sequencer: regulators, core reset, watchdog, modes
// assumes firmware strobes on the system clock, pins and supply flags async
//
// Operation
// - buck, then ldos, release reset once stable
// - external reset returns the power sequence to power-on; deep-off wake record kept
// - brownout forces shutdown
// - watchdog interrupt after 2 s unserviced
// - watchdog reset after 4 s unserviced
// - idle halts cpu, clocks keep running
// - sleep: only low-power clock, cpu waits
// - sleep gates clocks, retains state, lowers voltage
// - sleep exits on wake period or pin
// - power-down-sleep: radio off, retention kept
// - extended power-down-sleep: same outputs as power-down-sleep, ram retained
// - deep-off: only pin domain powered
// - deep-off timed wake keeps low-power clock
// - record deep-off exit and wake cause
// - debug access disabled at every power-up
// - lockout keeps debug off, blocks raw reads only while core_reset_n_out is high
`timescale 1ns/1ps
module pmrs_top
  import pmrs_pkg::*;
#(
  parameter int unsigned WDOG_IRQ_CYCLES = WDOG_IRQ_CYC,
  parameter int unsigned WDOG_RST_CYCLES = WDOG_RST_CYC,
  parameter int unsigned SETTLE_CYCLES   = REG_SETTLE_CYC
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  input  wire logic              external_reset_n_in,
  input  wire logic              supply_ok_in,
  input  wire logic              brownout_in,
  input  wire logic              ldo_stable_in,
  input  wire logic              low_power_clock_tick_in,
  input  wire logic              wake_pin_in,
  input  wire logic              wdog_service_in,
  input  wire logic              irq_pending_in,
  input  wire logic [2:0]        mode_req_in,
  input  wire logic              mode_req_valid_in,
  input  wire logic              timed_wake_in,
  input  wire logic [WAKE_W-1:0] wake_period_in,
  input  wire logic              lockout_present_in,
  input  wire logic              debug_unlock_in,
  input  wire logic              wake_record_clear_in,
  output logic                   buck_en_out,
  output logic                   ldo_en_out,
  output logic                   ldo_low_v_out,
  output logic                   core_reset_n_out,
  output logic                   core_power_out,
  output logic                   radio_power_out,
  output logic                   ram_retain_out,
  output logic                   cpu_halt_out,
  output logic                   cpu_wfi_out,
  output logic                   sys_clk_en_out,
  output logic                   bus_clk_en_out,
  output logic                   low_power_clock_en_out,
  output logic                   wdog_irq_out,
  output logic                   debug_en_out,
  output logic                   raw_read_block_out,
  output logic                   from_deep_off_out,
  output logic [1:0]             wake_cause_out
);
  // refuse timing values that the counters cannot serve
  if (WDOG_IRQ_CYCLES == 0 || WDOG_RST_CYCLES <= WDOG_IRQ_CYCLES || SETTLE_CYCLES == 0) begin : g_bad_timing
    $error("pmrs_top: bad timing parameters");
  end

  // synchronised pins and analog flags
  logic external_reset_n_n_s, supply_s, bo_s, stable_s, lpc_s, pin_s;
  pmrs_sync #(.W(6)) pmrs_sync_i (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .d_in       ({external_reset_n_in, supply_ok_in, brownout_in, ldo_stable_in,
                  low_power_clock_tick_in, wake_pin_in}),
    .q_out      ({external_reset_n_n_s, supply_s, bo_s, stable_s, lpc_s, pin_s})
  );

  pmrs_state_e        state;
  logic [31:0]        settle_cnt;
  logic [31:0]        wdog_cnt;
  logic               wdog_bite;
  logic [WAKE_W-1:0]  wake_cnt;
  logic               timed_mode;
  logic               lpc_d;
  logic               pin_d;
  logic               lpc_edge;
  logic               pin_edge;
  logic               timer_hit;
  logic               in_low;
  logic               por;

  assign lpc_edge  = lpc_s & ~lpc_d;
  assign pin_edge  = pin_s & ~pin_d;
  assign in_low    = (state == PMRS_SLEEP) || (state == PMRS_PDS) ||
                     (state == PMRS_EXTENDED_POWER_DOWN_SLEEP) || (state == PMRS_DEEP_OFF);
  assign timer_hit = in_low && timed_mode && lpc_edge && (wake_cnt == '0);
  // low external_reset_n forces power-on state, active low
  assign por       = ~external_reset_n_n_s | wdog_bite;

  // edge detect registers
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lpc_d <= 1'b0;
      pin_d <= 1'b0;
    end else begin
      lpc_d <= lpc_s;
      pin_d <= pin_s;
    end
  end

  // main power sequence and mode machine
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state      <= PMRS_OFF;
      settle_cnt <= '0;
    end else if (por) begin
      state      <= PMRS_OFF;
      settle_cnt <= '0;
    end else if (bo_s) begin
      state      <= PMRS_SHUTDOWN;
    end else begin
      case (state)
        PMRS_OFF, PMRS_SHUTDOWN: begin
          settle_cnt <= '0;
          if (supply_s)
            state <= PMRS_BUCK;
        end
        PMRS_BUCK: begin
          if (settle_cnt >= SETTLE_CYCLES - 1) begin
            settle_cnt <= '0;
            state      <= PMRS_LDO;
          end else begin
            settle_cnt <= settle_cnt + 32'h1;
          end
        end
        PMRS_LDO: begin
          if (settle_cnt >= SETTLE_CYCLES - 1) begin
            if (stable_s)
              state <= PMRS_ACTIVE;
          end else begin
            settle_cnt <= settle_cnt + 32'h1;
          end
        end
        PMRS_ACTIVE: begin
          if (mode_req_valid_in) begin
            case (mode_req_in)
              REQ_IDLE:  state <= PMRS_IDLE;
              REQ_SLEEP: state <= PMRS_SLEEP;
              REQ_PDS:   state <= PMRS_PDS;
              REQ_EXTENDED_POWER_DOWN_SLEEP:  state <= PMRS_EXTENDED_POWER_DOWN_SLEEP;
              REQ_OFF:   state <= PMRS_DEEP_OFF;
              default:   state <= PMRS_ACTIVE;
            endcase
          end
        end
        PMRS_IDLE: begin
          if (irq_pending_in || pin_edge)
            state <= PMRS_ACTIVE;
        end
        PMRS_SLEEP, PMRS_PDS, PMRS_EXTENDED_POWER_DOWN_SLEEP: begin
          if (timer_hit || pin_edge)
            state <= PMRS_ACTIVE;
        end
        PMRS_DEEP_OFF: begin
          if (timer_hit || pin_edge) begin
            settle_cnt <= '0;
            state      <= PMRS_BUCK;
          end
        end
        default: state <= PMRS_OFF;
      endcase
    end
  end

  // wake period counter on the low-power clock tick
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wake_cnt   <= '0;
      timed_mode <= 1'b0;
    end else if (state == PMRS_ACTIVE && mode_req_valid_in) begin
      wake_cnt   <= wake_period_in;
      timed_mode <= (mode_req_in != REQ_OFF) || timed_wake_in;
    end else if (in_low && lpc_edge && wake_cnt != '0) begin
      wake_cnt <= wake_cnt - {{(WAKE_W-1){1'b0}}, 1'b1};
    end
  end

  // watchdog count, restarted by any service strobe
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wdog_cnt     <= '0;
      wdog_irq_out <= 1'b0;
      wdog_bite    <= 1'b0;
    end else if (state != PMRS_ACTIVE && state != PMRS_IDLE) begin
      wdog_cnt     <= '0;
      wdog_irq_out <= 1'b0;
      wdog_bite    <= 1'b0;
    end else if (wdog_service_in) begin
      wdog_cnt     <= '0;
      wdog_irq_out <= 1'b0;
      wdog_bite    <= 1'b0;
    end else begin
      wdog_cnt  <= wdog_cnt + 32'h1;
      wdog_bite <= (wdog_cnt == WDOG_RST_CYCLES - 1);
      if (wdog_cnt == WDOG_IRQ_CYCLES - 1)
        wdog_irq_out <= 1'b1;
    end
  end

  // power, clock and reset outputs per state
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      buck_en_out            <= 1'b0;
      ldo_en_out             <= 1'b0;
      ldo_low_v_out          <= 1'b0;
      core_reset_n_out       <= 1'b0;
      core_power_out         <= 1'b0;
      radio_power_out        <= 1'b0;
      ram_retain_out         <= 1'b0;
      cpu_halt_out           <= 1'b0;
      cpu_wfi_out            <= 1'b0;
      sys_clk_en_out         <= 1'b0;
      bus_clk_en_out         <= 1'b0;
      low_power_clock_en_out <= 1'b0;
    end else begin
      buck_en_out      <= !(state inside {PMRS_OFF, PMRS_SHUTDOWN, PMRS_DEEP_OFF});
      ldo_en_out       <= state inside {PMRS_LDO, PMRS_ACTIVE, PMRS_IDLE, PMRS_SLEEP,
                                        PMRS_PDS, PMRS_EXTENDED_POWER_DOWN_SLEEP};
      ldo_low_v_out    <= state inside {PMRS_SLEEP, PMRS_PDS, PMRS_EXTENDED_POWER_DOWN_SLEEP};
      core_reset_n_out <= state inside {PMRS_ACTIVE, PMRS_IDLE, PMRS_SLEEP,
                                        PMRS_PDS, PMRS_EXTENDED_POWER_DOWN_SLEEP};
      core_power_out   <= state inside {PMRS_LDO, PMRS_ACTIVE, PMRS_IDLE, PMRS_SLEEP};
      radio_power_out  <= state inside {PMRS_ACTIVE, PMRS_IDLE, PMRS_SLEEP};
      ram_retain_out   <= state inside {PMRS_SLEEP, PMRS_PDS, PMRS_EXTENDED_POWER_DOWN_SLEEP};
      cpu_halt_out     <= state inside {PMRS_IDLE, PMRS_SLEEP};
      cpu_wfi_out      <= (state == PMRS_SLEEP);
      sys_clk_en_out   <= state inside {PMRS_ACTIVE, PMRS_IDLE};
      bus_clk_en_out   <= state inside {PMRS_ACTIVE, PMRS_IDLE};
      low_power_clock_en_out <= (state inside {PMRS_ACTIVE, PMRS_IDLE, PMRS_SLEEP,
                                               PMRS_PDS, PMRS_EXTENDED_POWER_DOWN_SLEEP}) ||
                                (state == PMRS_DEEP_OFF && timed_mode);
    end
  end

  // deep-off wake record, set wins over clear
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      from_deep_off_out <= 1'b0;
      wake_cause_out    <= CAUSE_NONE;
    end else if (state == PMRS_DEEP_OFF && !por && !bo_s && (timer_hit || pin_edge)) begin
      from_deep_off_out <= 1'b1;
      wake_cause_out    <= pin_edge ? CAUSE_PIN : CAUSE_TIMER;
    end else if (wake_record_clear_in) begin
      from_deep_off_out <= 1'b0;
      wake_cause_out    <= CAUSE_NONE;
    end
  end

  // debug lock, relocked on every power-up
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      debug_en_out       <= 1'b0;
      raw_read_block_out <= 1'b0;
    end else if (!core_reset_n_out) begin
      debug_en_out       <= 1'b0;
      raw_read_block_out <= 1'b0;
    end else if (lockout_present_in) begin
      debug_en_out       <= 1'b0;
      raw_read_block_out <= 1'b1;
    end else begin
      // raw reads blocked only while the lockout field is present
      raw_read_block_out <= 1'b0;
      if (debug_unlock_in)
        debug_en_out <= 1'b1;
    end
  end

  // checks
  wdog_irq_time_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (state == PMRS_ACTIVE && $past(state) == PMRS_ACTIVE && !wdog_service_in &&
     wdog_cnt == WDOG_IRQ_CYCLES - 1) |=> wdog_irq_out)
    else $error("watchdog interrupt late");
  wdog_bite_reset_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    wdog_bite |=> state == PMRS_OFF)
    else $error("watchdog did not reset");
  wdog_service_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    wdog_service_in |=> wdog_cnt == 0 && !wdog_irq_out)
    else $error("service did not restart watchdog");
  external_reset_n_por_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !external_reset_n_n_s |=> state == PMRS_OFF ##1 !core_reset_n_out)
    else $error("external reset ignored");
  brownout_off_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (bo_s && external_reset_n_n_s && !wdog_bite) |=> state == PMRS_SHUTDOWN)
    else $error("brownout not shut down");
  reset_order_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(core_reset_n_out) |-> ldo_en_out && buck_en_out && $past(stable_s, 2))
    else $error("core reset released early");
  sleep_clocks_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    cpu_wfi_out |-> !bus_clk_en_out && !sys_clk_en_out && low_power_clock_en_out)
    else $error("sleep clocks wrong");
  debug_lock_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    lockout_present_in && core_reset_n_out |=> !debug_en_out && raw_read_block_out)
    else $error("lockout not enforced");
  powerup_lock_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(core_reset_n_out) |-> !debug_en_out)
    else $error("debug open at power-up");
  deep_record_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (state == PMRS_DEEP_OFF && pin_edge && !por && !bo_s) |=> from_deep_off_out &&
     wake_cause_out == CAUSE_PIN)
    else $error("deep-off wake not recorded");

  reach_active_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) $rose(core_reset_n_out));
  sleep_wake_c:   cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    state == PMRS_SLEEP ##1 state == PMRS_ACTIVE);
  deep_wake_c:    cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) $rose(from_deep_off_out));
  wdog_irq_c:     cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) $rose(wdog_irq_out));
endmodule // pmrs_top

/* inc/pmrs_pkg.sv */
// package for the power mode and reset sequencer
// assumes a 10 MHz system clock and a low-power clock tick arriving on a pin
package pmrs_pkg;
  // clock rate
  localparam int unsigned CLK_HZ              = 10_000_000;
  // watchdog thresholds in seconds
  localparam int unsigned WDOG_IRQ_S          = 2;
  localparam int unsigned WDOG_RST_S          = 4;
  localparam int unsigned WDOG_IRQ_CYC        = WDOG_IRQ_S * CLK_HZ;
  localparam int unsigned WDOG_RST_CYC        = WDOG_RST_S * CLK_HZ;
  // regulator settle wait in microseconds
  localparam int unsigned REG_SETTLE_US       = 100;
  localparam int unsigned REG_SETTLE_CYC      = (REG_SETTLE_US * (CLK_HZ / 1_000_000) > 0) ?
                                                REG_SETTLE_US * (CLK_HZ / 1_000_000) : 1;
  // wake period counter width
  localparam int unsigned WAKE_W              = 16;
  // wake cause field
  localparam logic [1:0]  CAUSE_NONE          = 2'h0;
  localparam logic [1:0]  CAUSE_TIMER         = 2'h1;
  localparam logic [1:0]  CAUSE_PIN           = 2'h2;
  // low power mode request codes
  localparam logic [2:0]  REQ_IDLE            = 3'h1;
  localparam logic [2:0]  REQ_SLEEP           = 3'h2;
  localparam logic [2:0]  REQ_PDS             = 3'h3;
  localparam logic [2:0]  REQ_EXTENDED_POWER_DOWN_SLEEP            = 3'h4;
  localparam logic [2:0]  REQ_OFF             = 3'h5;

  typedef enum logic [3:0] {
    PMRS_OFF, PMRS_BUCK, PMRS_LDO, PMRS_ACTIVE, PMRS_IDLE, PMRS_SLEEP,
    PMRS_PDS, PMRS_EXTENDED_POWER_DOWN_SLEEP, PMRS_DEEP_OFF, PMRS_SHUTDOWN
  } pmrs_state_e;
endpackage

/* logic/pmrs_sync.sv */
// two flip-flop synchroniser, one per bit
// assumes inputs from outside the system clock domain
`timescale 1ns/1ps
module pmrs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta;

  // first stage read only by the second
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta  <= '0;
      q_out <= '0;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule // pmrs_sync

/* sim/pmrs_partner.sv */
// partner model: ldo settle response and the low-power clock source
// assumes regulator and clock enables come from the sequencer on the system clock
`timescale 1ns/1ps
module pmrs_partner (
  input  wire logic clk_sys_in,
  input  wire logic ldo_en_in,
  input  wire logic low_power_clock_en_in,
  output logic      ldo_stable_out,
  output logic      low_power_clock_tick_out
);
  logic [2:0] settle;
  logic [2:0] div;
  // ldo settles five cycles after enable, drops at once when disabled
  always_ff @(posedge clk_sys_in) begin
    if (ldo_en_in !== 1'b1) settle <= 3'h0;
    else if (settle != 3'h5) settle <= settle + 3'h1;
  end
  assign ldo_stable_out = (settle == 3'h5);
  // slow clock runs only while enabled and stands still otherwise
  always_ff @(posedge clk_sys_in) begin
    if (low_power_clock_en_in !== 1'b1) div <= 3'h0;
    else div <= div + 3'h1;
  end
  assign low_power_clock_tick_out = div[2];
endmodule // pmrs_partner

/* sim/pmrs_top_test.sv */
// testbench for the power mode and reset sequencer
// assumes shortened watchdog and settle counts and the partner model beside it
`timescale 1ns/1ps
module pmrs_top_test;
  import pmrs_pkg::*;
  localparam int unsigned IRQ_C = 20;
  localparam int unsigned RST_C = 40;
  logic              clk_sys_in = 1'b0;
  logic              rst_n_in = 1'b0;
  logic              external_reset_n_in = 1'b1;
  logic              supply_ok_in = 1'b1;
  logic              brownout_in = 1'b0;
  logic              ldo_stable_in;
  logic              low_power_clock_tick_in;
  logic              wake_pin_in = 1'b0;
  logic              wdog_service_in = 1'b0;
  logic              irq_pending_in = 1'b0;
  logic [2:0]        mode_req_in = 3'h0;
  logic              mode_req_valid_in = 1'b0;
  logic              timed_wake_in = 1'b0;
  logic [WAKE_W-1:0] wake_period_in = 16'hffff;
  logic              lockout_present_in = 1'b0;
  logic              debug_unlock_in = 1'b0;
  logic              wake_record_clear_in = 1'b0;
  logic              buck_en_out, ldo_en_out, ldo_low_v_out, core_reset_n_out, core_power_out;
  logic              radio_power_out, ram_retain_out, cpu_halt_out, cpu_wfi_out, sys_clk_en_out;
  logic              bus_clk_en_out, low_power_clock_en_out, wdog_irq_out, debug_en_out;
  logic              raw_read_block_out, from_deep_off_out;
  logic [1:0]        wake_cause_out;
  int                fails = 0;
  int                total_checks = 0;
  int                cycles = 0;
  int                i;

  pmrs_top #(.WDOG_IRQ_CYCLES(IRQ_C), .WDOG_RST_CYCLES(RST_C), .SETTLE_CYCLES(3)) pmrs_top_i (
    .clk_sys_in, .rst_n_in, .external_reset_n_in, .supply_ok_in, .brownout_in, .ldo_stable_in,
    .low_power_clock_tick_in, .wake_pin_in, .wdog_service_in, .irq_pending_in, .mode_req_in,
    .mode_req_valid_in, .timed_wake_in, .wake_period_in, .lockout_present_in, .debug_unlock_in,
    .wake_record_clear_in, .buck_en_out, .ldo_en_out, .ldo_low_v_out, .core_reset_n_out,
    .core_power_out, .radio_power_out, .ram_retain_out, .cpu_halt_out, .cpu_wfi_out, .sys_clk_en_out,
    .bus_clk_en_out, .low_power_clock_en_out, .wdog_irq_out, .debug_en_out, .raw_read_block_out,
    .from_deep_off_out, .wake_cause_out);

  pmrs_partner pmrs_partner_i (
    .clk_sys_in, .ldo_en_in(ldo_en_out), .low_power_clock_en_in(low_power_clock_en_out),
    .ldo_stable_out(ldo_stable_in), .low_power_clock_tick_out(low_power_clock_tick_in));

  // system clock, 100 ns period
  always #50 clk_sys_in = ~clk_sys_in;

  // hang guard
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // drive just after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic ck(input string name, input logic [9:0] exp, input logic [9:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // wait for the core to run again, then service the watchdog
  task automatic wait_run();
    for (i = 0; i < 300 && !(core_reset_n_out === 1'b1 && cpu_halt_out === 1'b0 && cpu_wfi_out === 1'b0
         && sys_clk_en_out === 1'b1); i++) cyc(1);
    ck("core running", 10'h1, {9'h0, i < 300});
    wdog_service_in = 1'b1;
    cyc(1);
    wdog_service_in = 1'b0;
  endtask

  task automatic t_powerup();
    for (i = 0; i < 100 && buck_en_out !== 1'b1; i++) cyc(1);
    ck("buck first", 10'h1, {8'h0, ldo_en_out, buck_en_out});
    for (i = 0; i < 100 && ldo_en_out !== 1'b1; i++) cyc(1);
    ck("reset held", 10'h2, {8'h0, buck_en_out, core_reset_n_out});
    for (i = 0; i < 100 && core_reset_n_out !== 1'b1; i++) cyc(1);
    ck("release after stable", 10'h3, {8'h0, ldo_stable_in, core_reset_n_out});
    ck("debug locked", 10'h0, {9'h0, debug_en_out});
    wait_run();
  endtask

  // interrupt after the first threshold, cleared by service, reset after the second
  task automatic t_wdog();
    int j;
    cyc(IRQ_C - 6);
    ck("irq early", 10'h0, {9'h0, wdog_irq_out});
    wdog_service_in = 1'b1;
    cyc(1);
    wdog_service_in = 1'b0;
    for (i = 0; i < IRQ_C + 10 && wdog_irq_out !== 1'b1; i++) cyc(1);
    ck("irq delay", 10'h1, {9'h0, i >= IRQ_C - 5 && i <= IRQ_C + 3});
    wdog_service_in = 1'b1;
    cyc(1);
    wdog_service_in = 1'b0;
    ck("irq cleared", 10'h0, {9'h0, wdog_irq_out});
    for (j = 0; j < RST_C + 10 && core_reset_n_out === 1'b1; j++) cyc(1);
    ck("bite delay", 10'h1, {9'h0, j >= RST_C - 5 && j <= RST_C + 3});
    wait_run();
  endtask

  // wake kind 0 timer, 1 pin, 2 interrupt; vector radio core ram lpc sys bus halt wfi buck low_v
  task automatic t_mode(input logic [2:0] code, input logic timed, input int kind,
                        input logic [9:0] mask, input logic [9:0] exp, input logic [1:0] cause);
    mode_req_in = code;
    timed_wake_in = timed;
    wake_period_in = (kind == 0) ? 16'h0002 : 16'hffff;
    mode_req_valid_in = 1'b1;
    cyc(1);
    mode_req_valid_in = 1'b0;
    cyc(4);
    ck("mode outputs", exp & mask, mask & {radio_power_out, core_power_out, ram_retain_out,
       low_power_clock_en_out, sys_clk_en_out, bus_clk_en_out, cpu_halt_out, cpu_wfi_out,
       buck_en_out, ldo_low_v_out});
    wake_pin_in = (kind == 1);
    irq_pending_in = (kind == 2);
    cyc(6);
    wake_pin_in = 1'b0;
    wait_run();
    irq_pending_in = 1'b0;
    if (code == REQ_OFF) begin
      ck("wake record", {7'h0, 1'b1, cause}, {7'h0, from_deep_off_out, wake_cause_out});
      wake_record_clear_in = 1'b1;
      cyc(1);
      wake_record_clear_in = 1'b0;
      cyc(3);
      ck("record cleared", 10'h0, {9'h0, from_deep_off_out});
    end
  endtask

  task automatic t_lock();
    lockout_present_in = 1'b1;
    debug_unlock_in = 1'b1;
    cyc(1);
    debug_unlock_in = 1'b0;
    cyc(4);
    ck("lockout", 10'h1, {8'h0, debug_en_out, raw_read_block_out});
    lockout_present_in = 1'b0;
    debug_unlock_in = 1'b1;
    cyc(1);
    debug_unlock_in = 1'b0;
    cyc(4);
    ck("unlock", 10'h2, {8'h0, debug_en_out, raw_read_block_out});
    external_reset_n_in = 1'b0;
    cyc(8);
    ck("pin reset", 10'h0, {7'h0, buck_en_out, core_reset_n_out, debug_en_out});
    external_reset_n_in = 1'b1;
    t_powerup();
    brownout_in = 1'b1;
    cyc(6);
    ck("brownout", 10'h0, {8'h0, buck_en_out, core_reset_n_out});
    brownout_in = 1'b0;
    wait_run();
  endtask

  // main sequence
  initial begin
    cyc(20);
    rst_n_in = 1'b1;
    t_powerup();
    t_wdog();
    t_mode(REQ_IDLE, 1'b0, 2, 10'h3ff, 10'h37a, CAUSE_NONE);
    t_mode(REQ_SLEEP, 1'b0, 1, 10'h3ff, 10'h3cf, CAUSE_NONE);
    t_mode(REQ_PDS, 1'b0, 0, 10'h3ff, 10'h0c3, CAUSE_NONE);
    t_mode(REQ_EXTENDED_POWER_DOWN_SLEEP, 1'b0, 1, 10'h3ff, 10'h0c3, CAUSE_NONE);
    t_mode(REQ_OFF, 1'b1, 0, 10'h3ff, 10'h040, CAUSE_TIMER);
    t_mode(REQ_OFF, 1'b0, 1, 10'h3ff, 10'h000, CAUSE_PIN);
    t_lock();
    end_of_test();
  end
endmodule // pmrs_top_test
